/* File: isl_latch_bank.sv */
// Behaviour
// R1 - sixteen DSP event flags sit in bits 0 to 15 at 0x180A, each set by a rising edge of its input, reset 0.
// R2 - a latched bit stays set until software writes 1 to it; writing 0 leaves it alone.
// R3 - the speaker short flag, bit 6 at 0x180B, sets on both edges of its detector.
// R4 - bits 0 to 3 at 0x180B catch left phone, right phone, earpiece pos and neg shorts on rising edges only.
// R5 - 0x180C catches enable-done rising edges: speaker bit 6, right/neg bit 1, left/pos bit 0.
// R6 - 0x180D catches disable-done rising edges: speaker bit 6, right/neg bit 1, left/pos bit 0.
// R7 - a masked source neither sets its flag nor raises the interrupt request.
// R8 - the interrupt request is the OR of all flags and stays up until all are cleared.
// R9 - an edge in the same cycle as a write-one-to-clear of that bit leaves the bit set.
`timescale 1ns/1ps
module isl_latch_bank
  import isl_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire isl_pkg::isl_sources_t sources,
  input wire isl_pkg::isl_masks_t masks,
  input wire isl_pkg::isl_reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  output logic first_interrupt_request
);
  import isl_pkg::*;

  logic [63:0] src_vec;
  logic [63:0] mask_vec;
  logic [63:0] sync1, sync2, prev;
  logic [63:0] next_sync1, next_sync2, next_prev;
  logic [63:0] ev;
  logic [63:0] clr;
  logic [63:0] stat, next_stat;
  logic irq, next_irq;
  logic [15:0] rdata, next_rdata;

  // the flattened bank below is four 16-bit words; any other package shape breaks the slices
  if (NUM_REGS * REG_W != 64)
  begin : g_bank_shape_check
    $error("status bank shape does not match the 64-bit layout");
  end

  // flatten sources into the register layout: dsp, short, enable done, disable done
  always_comb
  begin
    src_vec = '0;
    src_vec[15:0] = sources.dsp_event;
    src_vec[16 + LEFT_BIT] = sources.left_phone_short;
    src_vec[16 + RIGHT_BIT] = sources.right_phone_short;
    src_vec[16 + EAR_POS_BIT] = sources.earpiece_pos_short;
    src_vec[16 + EAR_NEG_BIT] = sources.earpiece_neg_short;
    src_vec[16 + SPEAKER_BIT] = sources.speaker_short;
    src_vec[32 + LEFT_BIT] = sources.left_out_on_done;
    src_vec[32 + RIGHT_BIT] = sources.right_out_on_done;
    src_vec[32 + SPEAKER_BIT] = sources.speaker_on_done;
    src_vec[48 + LEFT_BIT] = sources.left_out_off_done;
    src_vec[48 + RIGHT_BIT] = sources.right_out_off_done;
    src_vec[48 + SPEAKER_BIT] = sources.speaker_off_done;
    mask_vec = {masks.output_disable_done, masks.output_enable_done, masks.output_short, masks.dsp_event};
  end

  // sources come from other analog and dsp domains, so two flops before any edge logic
  // a pulse shorter than one clock can fall between samples and be missed
  always_comb
  begin
    next_sync1 = src_vec;
    next_sync2 = sync1;
    next_prev = sync2;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end
    else
    begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev <= next_prev;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++)
    begin : g_edge
      // unimplemented positions never see an event, so they read zero forever
      // the mask gates only the set path; a flag already up stays up if masked later
      assign ev[gi] = IMPLEMENTED[gi] & ~mask_vec[gi] &
                      ((sync2[gi] & ~prev[gi]) | (BOTH_EDGES[gi] & ~sync2[gi] & prev[gi])); // R1 R3 R4 R5 R6 R7
    end
  endgenerate

  always_comb
  begin
    clr = '0;
    if (reg_req.write)
    begin
      case (reg_req.addr)
        DSP_EVENT_STATUS_ADDR: clr[15:0] = reg_req.wdata;
        OUTPUT_SHORT_STATUS_ADDR: clr[31:16] = reg_req.wdata;
        OUTPUT_ENABLE_DONE_STATUS_ADDR: clr[47:32] = reg_req.wdata;
        OUTPUT_DISABLE_DONE_STATUS_ADDR: clr[63:48] = reg_req.wdata;
        default: clr = '0;
      endcase
    end
    // set wins over clear, so an edge landing in the clearing cycle is never lost
    next_stat = (stat & ~clr) | ev; // R2 R9
    // the request follows the next flags, so it moves in the same cycle as they do
    next_irq = |next_stat; // R8
    case (reg_req.addr)
      DSP_EVENT_STATUS_ADDR: next_rdata = stat[15:0];
      OUTPUT_SHORT_STATUS_ADDR: next_rdata = stat[31:16];
      OUTPUT_ENABLE_DONE_STATUS_ADDR: next_rdata = stat[47:32];
      OUTPUT_DISABLE_DONE_STATUS_ADDR: next_rdata = stat[63:48];
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stat <= {NUM_REGS{STATUS_RESET}};
      irq <= 1'b0;
      rdata <= 16'h0000;
    end
    else
    begin
      stat <= next_stat;
      irq <= next_irq;
      rdata <= next_rdata;
    end
  end

  assign reg_rdata = rdata;
  assign first_interrupt_request = irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence spk_rise_s;
    sync2[16 + SPEAKER_BIT] && !prev[16 + SPEAKER_BIT];
  endsequence
  sequence spk_fall_s;
    !sync2[16 + SPEAKER_BIT] && prev[16 + SPEAKER_BIT];
  endsequence
  sequence ear_neg_rise_s;
    sync2[16 + EAR_NEG_BIT] && !prev[16 + EAR_NEG_BIT];
  endsequence
  sequence dsp_top_fall_s;
    !sync2[15] && prev[15];
  endsequence
  sequence left_on_rise_s;
    sync2[32 + LEFT_BIT] && !prev[32 + LEFT_BIT];
  endsequence
  sequence left_off_rise_s;
    sync2[48 + LEFT_BIT] && !prev[48 + LEFT_BIT];
  endsequence

  dsp_rise_set_a: assert property (sync2[0] && !prev[0] && !mask_vec[0] |=> stat[0]) // R1
    else $error("dsp event rise did not set flag");
  zero_write_hold_a: assert property (stat[5] && !(reg_req.write && reg_req.addr == DSP_EVENT_STATUS_ADDR // R2
    && reg_req.wdata[5]) |=> stat[5])
    else $error("flag lost without a clearing write");
  one_write_clear_a: assert property (reg_req.write && reg_req.addr == OUTPUT_SHORT_STATUS_ADDR // R2
    && reg_req.wdata[0] && !ev[16] |=> !stat[16])
    else $error("write of one did not clear flag");
  spk_both_edges_a: assert property ((spk_rise_s or spk_fall_s) ##0 !mask_vec[16 + SPEAKER_BIT] // R3
    |=> stat[16 + SPEAKER_BIT])
    else $error("speaker short edge not caught");
  phone_fall_ignore_a: assert property (!sync2[16] && prev[16] && !stat[16] |=> !stat[16]) // R4
    else $error("falling edge set a phone short flag");
  on_done_rise_a: assert property (sync2[32 + SPEAKER_BIT] && !prev[32 + SPEAKER_BIT] // R5
    && !mask_vec[32 + SPEAKER_BIT] |=> stat[32 + SPEAKER_BIT])
    else $error("enable done not caught");
  off_done_rise_a: assert property (sync2[48 + RIGHT_BIT] && !prev[48 + RIGHT_BIT] // R6
    && !mask_vec[48 + RIGHT_BIT] |=> stat[48 + RIGHT_BIT])
    else $error("disable done not caught");
  masked_no_set_a: assert property (mask_vec[3] && !stat[3] |=> !stat[3]) // R7
    else $error("masked source set its flag");
  irq_is_or_a: assert property (first_interrupt_request == (|stat)) // R8
    else $error("interrupt request differs from OR of flags");
  set_beats_clear_a: assert property (ev[1] && clr[1] |=> stat[1] ##1 (stat[1] || $past(clr[1]))) // R9
    else $error("event lost against clear");
  dsp_fall_ignore_a: assert property (dsp_top_fall_s ##0 !stat[15] |=> !stat[15]) // R1
    else $error("falling edge set a dsp event flag");
  ear_neg_rise_a: assert property (ear_neg_rise_s ##0 !mask_vec[16 + EAR_NEG_BIT] // R4
    |=> stat[16 + EAR_NEG_BIT])
    else $error("earpiece short edge not caught");
  left_on_done_a: assert property (left_on_rise_s ##0 !mask_vec[32 + LEFT_BIT] // R5
    |=> stat[32 + LEFT_BIT])
    else $error("left enable done not caught");
  left_off_done_a: assert property (left_off_rise_s ##0 !mask_vec[48 + LEFT_BIT] // R6
    |=> stat[48 + LEFT_BIT])
    else $error("left disable done not caught");
  spk_masked_hold_a: assert property (mask_vec[16 + SPEAKER_BIT] && !stat[16 + SPEAKER_BIT] // R7
    |=> !stat[16 + SPEAKER_BIT])
    else $error("masked speaker short set its flag");
  quiet_no_irq_a: assert property (!first_interrupt_request && ev == '0 |=> !first_interrupt_request) // R7
    else $error("request rose with no unmasked event");
  irq_holds_a: assert property (first_interrupt_request && (stat & ~clr) != '0 |=> first_interrupt_request) // R8
    else $error("request fell while a flag stayed set");
  dsp_readback_a: assert property (reg_req.addr == DSP_EVENT_STATUS_ADDR // R1
    |=> reg_rdata == $past(stat[15:0]))
    else $error("dsp event word read back wrong");
  short_readback_a: assert property (reg_req.addr == OUTPUT_SHORT_STATUS_ADDR // R4
    |=> reg_rdata == $past(stat[31:16]))
    else $error("short word read back wrong");
  on_done_readback_a: assert property (reg_req.addr == OUTPUT_ENABLE_DONE_STATUS_ADDR // R5
    |=> reg_rdata == $past(stat[47:32]))
    else $error("enable done word read back wrong");
  off_done_readback_a: assert property (reg_req.addr == OUTPUT_DISABLE_DONE_STATUS_ADDR // R6
    |=> reg_rdata == $past(stat[63:48]))
    else $error("disable done word read back wrong");
  stray_write_keep_a: assert property (reg_req.write && (reg_req.addr < DSP_EVENT_STATUS_ADDR // R2
    || reg_req.addr > OUTPUT_DISABLE_DONE_STATUS_ADDR) |=> (stat & $past(stat)) == $past(stat))
    else $error("write to an unmapped address cleared a flag");

  // reset has its own check, so it overrides the default disable
  reset_clears_a: assert property (disable iff (1'b0) // R1
    reset |=> stat == '0 && reg_rdata == 16'h0000 && !first_interrupt_request)
    else $error("reset left a flag, read word or request set");
endmodule : isl_latch_bank

/* File: isl_pkg.sv */
package isl_pkg;
  localparam logic [15:0] DSP_EVENT_STATUS_ADDR = 16'h180a;
  localparam logic [15:0] OUTPUT_SHORT_STATUS_ADDR = 16'h180b;
  localparam logic [15:0] OUTPUT_ENABLE_DONE_STATUS_ADDR = 16'h180c;
  localparam logic [15:0] OUTPUT_DISABLE_DONE_STATUS_ADDR = 16'h180d;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam int NUM_REGS = 4;
  localparam int REG_W = 16;
  localparam int LEFT_BIT = 0;
  localparam int RIGHT_BIT = 1;
  localparam int EAR_POS_BIT = 2;
  localparam int EAR_NEG_BIT = 3;
  localparam int SPEAKER_BIT = 6;
  // bits of the flattened 64-bit status bank that exist, and those that catch both edges
  localparam logic [63:0] IMPLEMENTED = 64'h0043_0043_004f_ffff;
  localparam logic [63:0] BOTH_EDGES = 64'h0000_0000_0040_0000;

  typedef struct packed {
    logic [15:0] dsp_event;
    logic speaker_short;
    logic left_phone_short;
    logic right_phone_short;
    logic earpiece_pos_short;
    logic earpiece_neg_short;
    logic speaker_on_done;
    logic right_out_on_done;
    logic left_out_on_done;
    logic speaker_off_done;
    logic right_out_off_done;
    logic left_out_off_done;
  } isl_sources_t;

  typedef struct packed {
    logic [15:0] dsp_event;
    logic [15:0] output_short;
    logic [15:0] output_enable_done;
    logic [15:0] output_disable_done;
  } isl_masks_t;

  typedef struct packed {
    logic [15:0] addr;
    logic write;
    logic [15:0] wdata;
  } isl_reg_req_t;
endpackage : isl_pkg

/* File: isl_host.sv */
`timescale 1ns/1ps
module isl_host
  import isl_pkg::*;
(
  input wire logic clk,
  output isl_pkg::isl_reg_req_t reg_req
);
  initial reg_req = '0;
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_req <= '{a, 1'b1, d};
    @(posedge clk);
    reg_req.write <= 1'b0;
  endtask : wr
  // the read answer lags the address by one edge, so hold it two
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    reg_req.addr <= a;
    repeat (2) @(posedge clk);
  endtask : rd
endmodule : isl_host

/* File: tb_isl_latch_bank.sv */
`timescale 1ns/1ps
module tb_isl_latch_bank;
  import isl_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  isl_sources_t sources = '0;
  isl_masks_t masks = '0;
  isl_reg_req_t reg_req;
  logic [15:0] reg_rdata;
  logic first_interrupt_request;
  logic [63:0] st = '0;
  logic [63:0] pv = '0;
  isl_sources_t src;
  logic [63:0] mv;
  logic [31:0] r;
  logic [15:0] d;
  int seed = 36;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int ai;
  always #50 clk = ~clk;
  isl_host isl_host_inst (.clk(clk), .reg_req(reg_req));
  isl_latch_bank isl_latch_bank_inst (.clk(clk), .reset(reset), .sources(sources), .masks(masks),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .first_interrupt_request(first_interrupt_request));
  function automatic logic [63:0] lvec(input isl_sources_t s);
    return {9'h0, s.speaker_off_done, 4'h0, s.right_out_off_done, s.left_out_off_done,
      9'h0, s.speaker_on_done, 4'h0, s.right_out_on_done, s.left_out_on_done,
      9'h0, s.speaker_short, 2'h0, s.earpiece_neg_short, s.earpiece_pos_short,
      s.right_phone_short, s.left_phone_short, s.dsp_event};
  endfunction : lvec
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // drives sources and masks at an edge and moves the model's flags by the same rules
  task automatic drive(input isl_sources_t s, input logic [63:0] m);
    logic [63:0] n;
    sources <= s;
    masks <= '{m[15:0], m[31:16], m[47:32], m[63:48]};
    n = lvec(s);
    st = st | (~m & ((n & ~pv) | (pv & ~n & BOTH_EDGES)));
    pv = n;
  endtask : drive
  task automatic check_all;
    for (int a = 0; a < 5; a++)
    begin
      isl_host_inst.rd(16'h180a + 16'(a));
      #1;
      chk("status", (a < 4) ? st[a*16 +: 16] : 16'h0000, reg_rdata);
    end
    chk("irq", {15'h0, |st}, {15'h0, first_interrupt_request});
  endtask : check_all
  task automatic report_and_stop;
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int k = 0; k < 60; k++)
    begin
      r = $random(seed);
      // sparse masks so most events still land
      mv = {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
      @(posedge clk);
      drive(isl_sources_t'(r[26:0]), mv);
      repeat (5) @(posedge clk);
      ai = $unsigned($random(seed)) % 5;
      d = 16'($random(seed));
      isl_host_inst.wr(16'h180a + 16'(ai), d);
      if (ai < 4)
        st[ai*16 +: 16] = st[ai*16 +: 16] & ~d;
      check_all();
    end
    // dsp event 1 rises into the very cycle that writes its clear; the set must win, so the model keeps it
    @(posedge clk);
    drive('0, '0);
    repeat (4) @(posedge clk);
    src = '0;
    src.dsp_event[1] = 1'b1;
    drive(src, '0);
    @(posedge clk);
    isl_host_inst.wr(16'h180a, 16'h0002);
    check_all();
    for (int a = 0; a < 4; a++)
      isl_host_inst.wr(16'h180a + 16'(a), 16'hffff);
    repeat (2) @(posedge clk);
    #1;
    chk("irq clear", 16'h0000, {15'h0, first_interrupt_request});
    // mid-run reset with every source low, so the release shows no false edge
    @(posedge clk);
    drive('0, '0);
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    st = '0;
    check_all();
    report_and_stop();
  end
endmodule : tb_isl_latch_bank
